// ===== clkrst_cfg.svh
`ifndef CLKRST_CFG_SVH
`define CLKRST_CFG_SVH
// 40 MHz system clock; one core cycle = one enable pulse every CORE_DIV clocks
`define PLL_MULT            4
`define CORE_DIV            2
`define LOCK_REF_PERIODS    2500
`define LOCK_CORE_CYCLES    (`LOCK_REF_PERIODS * `PLL_MULT)
`define OSC_START_CYCLES    1000
`define WAKE_MAX_CYCLES     15
`define WAKE_CYCLES         10
`define IDLE_STOP_CYCLES    4
`define RESET_VEC_HALF      36
`define RESET_VEC_CYCLES    (`RESET_VEC_HALF / 2)
`define WD_RESET_CYCLES     8
`define CNT_W               16
`endif

// ===== clkrst_pkg.sv
package clkrst_pkg;
  typedef enum logic [1:0] {light_sleep_mode, deeper_sleep_mode, oscillator_off_halt_mode, no_sleep_mode} sleep_mode_t;
  typedef enum {st_osc_wait, st_pll_wait, st_run, st_idle_enter, st_idle, st_wake, st_reset_hold, st_reset_vec} seq_state_t;
endpackage

// ===== clock_reset_lowpower_seq.sv
`timescale 1ns/10ps
`include "clkrst_cfg.svh"
// Notes on behaviour
// - the core clock is the reference times a fixed four, with no ratio to program.
// - after the pll is enabled the core clock is synchronised within 2500 reference periods.
// - wakeup from either idle mode restarts the core clock and resumes execution within 15 cycles.
// - four core cycles after idle executes the core clock output stops high.
// - in halt mode the oscillator is powered off four core cycles after idle executes.
// - wakeup from halt restarts the oscillator and waits for start-up and lock before clocking the core.
// - any valid enabled interrupt or a reset wakes every low-power mode.
// - the reset vector runs no sooner than 18 core cycles after the reset pin goes high.
// - an internal reset drives the reset pin low for at least eight core cycles; only a watchdog reset in run, non-halt idle or at wake end gets this drive.
// - general pins other than clock output and flag output are undefined until the pll has locked.
module clock_reset_lowpower_seq
  import clkrst_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CORE_CYCLES,
  parameter int OSC_CYCLES  = `OSC_START_CYCLES
)
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_idle_exec,
  input  wire clkrst_pkg::sleep_mode_t i_sleep_mode,
  input  wire logic                  i_wake_irq,
  input  wire logic                  i_watchdog_reset,
  input  wire logic                  i_reset_pin_n,
  output logic                       o_reset_pin_n,
  output logic                       o_reset_pin_oe,
  output logic                       o_core_clock_output,
  output logic                       o_core_run,
  output logic                       o_osc_enable,
  output logic                       o_pll_locked,
  output logic                       o_reset_vector_go,
  output logic                       o_pins_valid
);
  import clkrst_pkg::*;

  // ==========================================
  // core tick
  logic tick;
  tick_divider #(.DIV(`CORE_DIV)) u_div
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .o_tick  (tick)
  );

  // ==========================================
  // reset pin synchroniser
  logic rs_meta_reg;
  logic rs_sync_reg;
  logic rs_prev_reg;
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      // pin idles high: reset to that level so no false edge follows reset
      rs_meta_reg <= 1'b1;
      rs_sync_reg <= 1'b1;
      rs_prev_reg <= 1'b1;
    end
    else
    begin
      rs_meta_reg <= i_reset_pin_n;
      rs_sync_reg <= rs_meta_reg;
      rs_prev_reg <= rs_sync_reg;
    end
  end
  // own drive excluded so a watchdog pulse is not taken as an external one
  wire ext_low  = !rs_sync_reg && !o_reset_pin_oe;
  wire rs_rise  = rs_sync_reg && !rs_prev_reg && !o_reset_pin_oe;

  // ==========================================
  // sequencer
  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [`CNT_W-1:0] cnt_reg;
  logic [`CNT_W-1:0] cnt_next;
  logic              halt_reg;
  logic              halt_next;
  wire               cnt_zero = (cnt_reg == '0);
  wire               wake     = i_wake_irq || ext_low || i_watchdog_reset;
  wire               is_halt  = (i_sleep_mode == oscillator_off_halt_mode);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = (tick && !cnt_zero) ? cnt_reg - `CNT_W'(1) : cnt_reg;
    halt_next  = halt_reg;
    case (state_reg)
      st_osc_wait:
        if (cnt_zero && tick)
        begin
          state_next = st_pll_wait;
          cnt_next   = `CNT_W'(LOCK_CYCLES - 1);
        end
      st_pll_wait:
        if (cnt_zero && tick)
          state_next = halt_reg ? st_wake : st_reset_hold;
      st_run:
        if (i_watchdog_reset)
        begin
          state_next = st_reset_hold;
          cnt_next   = `CNT_W'(`WD_RESET_CYCLES);
        end
        else if (ext_low)
          state_next = st_reset_hold;
        else if (i_idle_exec && i_sleep_mode != no_sleep_mode)
        begin
          state_next = st_idle_enter;
          halt_next  = is_halt;
          cnt_next   = `CNT_W'(`IDLE_STOP_CYCLES - 1);
        end
      st_idle_enter:
        if (cnt_zero && tick)
          state_next = st_idle;
      st_idle:
        // outside halt a reset wakes straight into reset hold so the pin rise is not missed; in halt it restarts the oscillator first
        if (!halt_reg && i_watchdog_reset)
        begin
          state_next = st_reset_hold;
          cnt_next   = `CNT_W'(`WD_RESET_CYCLES);
        end
        else if (!halt_reg && ext_low)
          state_next = st_reset_hold;
        else if (wake)
        begin
          if (halt_reg)
          begin
            state_next = st_osc_wait;
            cnt_next   = `CNT_W'(OSC_CYCLES - 1);
          end
          else
          begin
            state_next = st_wake;
            cnt_next   = `CNT_W'(`WAKE_CYCLES - 1);
          end
        end
      st_wake:
        if (cnt_zero)
        begin
          halt_next  = 1'b0;
          state_next = (ext_low || i_watchdog_reset) ? st_reset_hold : st_run;
          if (i_watchdog_reset)
            cnt_next = `CNT_W'(`WD_RESET_CYCLES);
        end
      st_reset_hold:
        if (rs_rise)
        begin
          state_next = st_reset_vec;
          cnt_next   = `CNT_W'(`RESET_VEC_CYCLES);
        end
        else if (o_reset_pin_oe && cnt_zero)
          cnt_next = cnt_reg;
      st_reset_vec:
        if (ext_low)
          state_next = st_reset_hold;
        else if (cnt_zero)
          state_next = st_run;
      default:
        state_next = st_osc_wait;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_reg <= st_osc_wait;
      cnt_reg   <= `CNT_W'(OSC_CYCLES - 1);
      halt_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      halt_reg  <= halt_next;
    end
  end

  // ==========================================
  // outputs
  wire pll_up    = (state_reg != st_osc_wait) && (state_reg != st_pll_wait);
  wire clk_on    = pll_up && (state_reg != st_idle);
  // drive lasts until the count has reached zero, so all eight core cycles are covered
  wire drive_rs  = (state_next == st_reset_hold) &&
                   (i_watchdog_reset || (o_reset_pin_oe && !cnt_zero));
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_reset_pin_n       <= 1'b1;
      o_reset_pin_oe      <= 1'b0;
      o_core_clock_output <= 1'b1;
      o_core_run          <= 1'b0;
      o_osc_enable        <= 1'b1;
      o_pll_locked        <= 1'b0;
      o_reset_vector_go   <= 1'b0;
      o_pins_valid        <= 1'b0;
    end
    else
    begin
      o_reset_pin_n       <= !drive_rs;
      o_reset_pin_oe      <= drive_rs;
      // stopped clock rests high; one clock high, one low is the core rate, four times the reference
      o_core_clock_output <= clk_on ? !o_core_clock_output : 1'b1;
      o_core_run          <= (state_next == st_run);
      o_osc_enable        <= !(state_next == st_idle && halt_reg);
      o_pll_locked        <= pll_up;
      o_reset_vector_go   <= (state_reg == st_reset_vec) && cnt_zero && !ext_low;
      o_pins_valid        <= pll_up;
    end
  end

  // ==========================================
  // assertion helpers: clocks since the synced rise, clocks of own drive
  logic [7:0] vec_age_reg;
  logic [7:0] drive_len_reg;
  always_ff @(posedge i_clock)
  begin
    if (i_rst || (rs_rise && state_reg == st_reset_hold))
      vec_age_reg <= 8'h00;
    else if (vec_age_reg != 8'hff)
      vec_age_reg <= vec_age_reg + 8'h01;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !o_reset_pin_oe)
      drive_len_reg <= 8'h00;
    else if (drive_len_reg != 8'hff)
      drive_len_reg <= drive_len_reg + 8'h01;
  end

  a_vec_delay: assert property (@(posedge i_clock) disable iff (i_rst)
    rs_rise && state_reg == st_reset_hold |-> !o_reset_vector_go [*8]) else $error("vector too early");
  a_vec_spacing: assert property (@(posedge i_clock) disable iff (i_rst)
    o_reset_vector_go |-> vec_age_reg >= 8'h24) else $error("vector before 36 clocks");
  a_wd_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_reset_pin_oe) |-> o_reset_pin_oe [*8]) else $error("reset drive short");
  a_drive_length: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_reset_pin_oe) |-> drive_len_reg >= 8'h10) else $error("reset drive under eight cycles");
  a_wake_time: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == st_idle && !halt_reg && i_wake_irq && !ext_low && !i_watchdog_reset |-> ##[1:30] o_core_run)
      else $error("wake late");
  a_clk_high: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == st_idle |=> o_core_clock_output) else $error("clock not high in idle");
  a_osc_off: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_osc_enable |-> halt_reg) else $error("osc off outside halt");
  a_halt_lock: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_pll_locked |-> !o_core_run) else $error("core runs unlocked");
endmodule

// ===== clock_reset_lowpower_seq_tb_top.sv
`timescale 1ns/10ps
module clock_reset_lowpower_seq_tb_top;
  import clkrst_pkg::*;
  logic        i_clock;
  logic        i_rst;
  logic        i_idle_exec;
  logic        i_wake_irq;
  logic        i_watchdog_reset;
  logic        hold_low;
  sleep_mode_t i_sleep_mode;
  logic        pin_n;
  logic        o_reset_pin_n;
  logic        o_reset_pin_oe;
  logic        o_core_clock_output;
  logic        o_core_run;
  logic        o_osc_enable;
  logic        o_pll_locked;
  logic        o_reset_vector_go;
  logic        o_pins_valid;
  logic [4:0]  mon;
  int          failures = 0;
  int          check_count = 0;
  int          n;
  assign mon = {!o_reset_pin_oe, o_pll_locked, o_osc_enable, o_reset_vector_go, o_core_run};
  // ==========================================
  // design and far side
  clock_reset_lowpower_seq #(.LOCK_CYCLES(8), .OSC_CYCLES(4)) u_dut
  (
    .i_clock(i_clock), .i_rst(i_rst), .i_idle_exec(i_idle_exec), .i_sleep_mode(i_sleep_mode),
    .i_wake_irq(i_wake_irq), .i_watchdog_reset(i_watchdog_reset), .i_reset_pin_n(pin_n),
    .o_reset_pin_n(o_reset_pin_n), .o_reset_pin_oe(o_reset_pin_oe),
    .o_core_clock_output(o_core_clock_output), .o_core_run(o_core_run),
    .o_osc_enable(o_osc_enable), .o_pll_locked(o_pll_locked),
    .o_reset_vector_go(o_reset_vector_go), .o_pins_valid(o_pins_valid)
  );
  ext_reset_src u_src
  (
    .i_hold_low(hold_low), .i_dev_pin_n(o_reset_pin_n), .i_dev_oe(o_reset_pin_oe), .o_pin_n(pin_n)
  );
  // ==========================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic wait_bit(input int b, input int lim, output int cnt);
    cnt = 0;
    while (mon[b] !== 1'b1 && cnt < lim)
    begin
      step(1);
      cnt++;
    end
  endtask
  // pin goes high, vector fetch no sooner than 36 clocks, then the core runs
  task automatic release_pin();
    hold_low = 1'b0;
    wait_bit(1, 200, n);
    check(n >= 36, 1);
    check(n < 200, 1);
    wait_bit(0, 4, n);
    check(o_core_run, 1);
  endtask
  // ==========================================
  // scenarios
  task automatic t_boot();
    wait_bit(3, 60, n);
    check(o_pll_locked, 1);
    check(o_pins_valid, 1);
    check(o_core_run, 0);
    release_pin();
  endtask
  task automatic t_sleep(input sleep_mode_t m);
    i_sleep_mode = m;
    i_idle_exec = 1'b1;
    step(1);
    i_idle_exec = 1'b0;
    step(12);
    check(o_core_run, m == no_sleep_mode);
    if (m == no_sleep_mode)
    begin
      n = o_core_clock_output;
      step(1);
      check(o_core_clock_output, !n[0]);
      step(1);
      check(o_core_clock_output, n[0]);
      return;
    end
    repeat (4)
    begin
      check(o_core_clock_output, 1);
      step(1);
    end
    check(o_osc_enable, m != oscillator_off_halt_mode);
    i_wake_irq = 1'b1;
    wait_bit(0, 200, n);
    i_wake_irq = 1'b0;
    check(o_core_run, 1);
    check(o_osc_enable, 1);
    if (m == oscillator_off_halt_mode)
      check(n >= 24, 1);
    else
      check(n <= 30, 1);
  endtask
  task automatic t_watchdog();
    i_watchdog_reset = 1'b1;
    step(1);
    i_watchdog_reset = 1'b0;
    check({o_reset_pin_oe, o_reset_pin_n}, 8'h02);
    wait_bit(4, 100, n);
    check(n >= 16, 1);
    release_pin();
  endtask
  task automatic t_reset_wake();
    i_sleep_mode = deeper_sleep_mode;
    i_idle_exec = 1'b1;
    step(1);
    i_idle_exec = 1'b0;
    step(12);
    hold_low = 1'b1;
    step(8);
    check(o_core_run, 0);
    release_pin();
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, main sequence
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = !i_clock;
  end
  initial
  begin
    #100000;
    failures++;
    end_of_test();
  end
  initial
  begin
    i_rst = 1'b1;
    i_idle_exec = 1'b0;
    i_wake_irq = 1'b0;
    i_watchdog_reset = 1'b0;
    hold_low = 1'b1;
    i_sleep_mode = no_sleep_mode;
    step(12);
    i_rst = 1'b0;
    t_boot();
    t_sleep(no_sleep_mode);
    t_sleep(light_sleep_mode);
    t_sleep(deeper_sleep_mode);
    t_sleep(oscillator_off_halt_mode);
    t_watchdog();
    t_reset_wake();
    end_of_test();
  end
endmodule

// ===== ext_reset_src.sv
`timescale 1ns/10ps
// ==========================================
// external reset source on a pulled-up pin
module ext_reset_src
(
  input  wire logic i_hold_low,
  input  wire logic i_dev_pin_n,
  input  wire logic i_dev_oe,
  output logic      o_pin_n
);
  // wired-and of both drivers; the pull-up wins only when neither pulls low
  assign o_pin_n = !(i_hold_low || (i_dev_oe && !i_dev_pin_n));
endmodule

// ===== tick_divider.sv
`timescale 1ns/10ps
`include "clkrst_cfg.svh"
// one-cycle enable every DIV input clocks
module tick_divider #(parameter int DIV = 2)
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  output logic      o_tick
);
  logic [7:0] count_reg;
  wire        wrap = (count_reg == 8'(DIV - 1));
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      count_reg <= 8'h00;
    else
      count_reg <= wrap ? 8'h00 : count_reg + 8'h01;
  end
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_tick <= 1'b0;
    else
      o_tick <= wrap;
  end
endmodule
